// ---- rtl/pwmct_top.v ----
// Purpose: two groups of pulse generators, eight down-counting timers,
//          dead-zone pairs and edge capture on the same pins
// Assumes: one clock clk, asynchronous active low reset arst_n,
//          control bits arrive as plain ports from the same clock domain
// Notes:   capture pins are synchronised by two flip-flops, so an edge
//          is seen three clocks after the pin moves and pulses shorter
//          than one clock may be lost
//          period and compare buffers are taken only at a start or at
//          zero, so software may write them at any time
//          a flag set and its clear in one cycle leave the flag set
//
// Overview of operation
// - four generators, eight outputs or four pairs
// - 8-bit prescaler then divider 1,2,4,8,16
// - two timers per generator, 16-bit counter, comparator
// - zero count sets that timer's own flag
// - interrupt only when matching enable bit set
// - auto-reload reloads period at zero, repeats
// - one-shot halts at zero, one interrupt only
// - pair zero/one follows timer zero, dead-zone zero
// - other pairs follow timers two, four, six
// - period and compare buffers load at zero
// - output goes high when count meets compare
// - capture enable turns output pin into input
// - capture shares timer; software configures it first
// - rising edge copies count to rising latch
// - falling edge copies count to falling latch
// - separate rising and falling capture interrupt enables
// - capture interrupt reloads same-index timer counter
// - writing one clears the interrupt flag
`timescale 1ns/1ps
`include "pwmct_defs.vh"

module pwmct_top
#(
  parameter CH   = 8,                    // timers and pins
  parameter GEN  = 4,                    // generators, two timers each
  parameter CW   = `PWMCT_CNT_W,         // counter width
  parameter PW   = `PWMCT_PRE_W,         // prescaler width
  parameter DW   = `PWMCT_DZ_W           // dead count width
)
(
  input  wire                            clk,
  input  wire                            arst_n,
  input  wire [GEN*PW-1:0]               prescale,
  input  wire [CH*`PWMCT_DIVSEL_W-1:0]   divSel,
  input  wire [CH*CW-1:0]                periodBuf,
  input  wire [CH*CW-1:0]                compareBuf,
  input  wire [CH-1:0]                   timerRun,
  input  wire [CH-1:0]                   autoReload,
  input  wire [CH-1:0]                   timerIrqEn,
  input  wire [GEN-1:0]                  pairDeadzoneEnable,
  input  wire [GEN*DW-1:0]               deadCount,
  input  wire [CH-1:0]                   captureEnable,
  input  wire [CH-1:0]                   riseLatchIrqEn,
  input  wire [CH-1:0]                   fallLatchIrqEn,
  input  wire [CH-1:0]                   timerFlagClr,
  input  wire [CH-1:0]                   riseFlagClr,
  input  wire [CH-1:0]                   fallFlagClr,
  input  wire [CH-1:0]                   pinIn,
  output wire [CH-1:0]                   pinOut,
  output wire [CH-1:0]                   pinOe,
  output wire [CH*CW-1:0]                counterValue,
  output wire [CH*CW-1:0]                risingCaptureLatch,
  output wire [CH*CW-1:0]                fallingCaptureLatch,
  output wire [CH-1:0]                   timerFlag,
  output wire [CH-1:0]                   riseFlag,
  output wire [CH-1:0]                   fallFlag,
  output wire [CH-1:0]                   timerRunning,
  output wire                            pulseIrq
);

  // codes above divide by sixteen fall back to no division
  // divider select code to the mask of divider bits that must be ones
  function [`PWMCT_DIVCNT_W-1:0] divMask;
    input [`PWMCT_DIVSEL_W-1:0] sel;
    begin
      case (sel)
        `PWMCT_DIV_2:  divMask = `PWMCT_MASK_2;
        `PWMCT_DIV_4:  divMask = `PWMCT_MASK_4;
        `PWMCT_DIV_8:  divMask = `PWMCT_MASK_8;
        `PWMCT_DIV_16: divMask = `PWMCT_MASK_16;
        default:       divMask = `PWMCT_MASK_1;
      endcase
    end
  endfunction

  // strobes shared between the generate loops
  wire [GEN-1:0] preTick;                 // prescaler terminal pulse
  wire [CH-1:0]  cntTick;                 // per-timer count pulse
  wire [CH-1:0]  rawHigh;                 // comparator output per timer
  wire [CH-1:0]  runW;                    // timer running per timer
  wire [CH-1:0]  irqSrc;                  // enabled pending sources
  reg            irq_q;                   // registered interrupt line

  // one 8-bit prescaler per generator
  // both timers of a generator step from this one terminal pulse
  genvar g;
  generate
    for (g = 0; g < GEN; g = g + 1)
    begin : genPre
      reg [PW-1:0] pre_q;                 // prescaler count
      wire [PW-1:0] preLim = prescale[g*PW +: PW];
      assign preTick[g] = (pre_q == preLim);
      // divides the clock by prescale plus one
      // a new limit below the count wraps through the full range once
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          pre_q <= `PWMCT_PRE_RST;
        else if (preTick[g])
          pre_q <= `PWMCT_PRE_RST;
        else
          pre_q <= pre_q + 1'b1;
      end
    end
  endgenerate

  // one timer, output stage and capture channel per index
  // odd timers keep counting in pair mode; only their pins are borrowed
  genvar i;
  generate
    for (i = 0; i < CH; i = i + 1)
    begin : genCh
      // fold the index into its pair master and its generator
      localparam M = (i / 2) * 2;         // pair master timer index
      localparam P = i / 2;               // pair and generator index
      reg [`PWMCT_DIVCNT_W-1:0] div_q;    // clock divider count
      reg [CW-1:0] cnt_q;                 // period down counter
      reg [CW-1:0] perA_q;                // active period
      reg [CW-1:0] cmpA_q;                // active compare
      reg          run_q;                 // counter running
      reg          runPrev_q;             // last timerRun, for start edge
      reg          tFlag_q;               // period zero flag
      reg          sync1_q;               // pin synchroniser first stage
      reg          sync2_q;               // pin synchroniser second stage
      reg          pinPrev_q;             // previous synced level
      reg [CW-1:0] riseL_q;               // rising capture latch
      reg [CW-1:0] fallL_q;               // falling capture latch
      reg          rFlag_q;               // rising capture flag
      reg          fFlag_q;               // falling capture flag
      reg [DW-1:0] dz_q;                  // dead-zone delay count
      reg          out_q;                 // registered pin value
      reg          oe_q;                  // registered pin enable
      // per-index slices of the packed buses
      wire [CW-1:0] perBuf = periodBuf[i*CW +: CW];
      wire [CW-1:0] cmpBuf = compareBuf[i*CW +: CW];
      wire [`PWMCT_DIVCNT_W-1:0] mask =
        divMask(divSel[i*`PWMCT_DIVSEL_W +: `PWMCT_DIVSEL_W]);
      wire zeroEvt  = run_q & cntTick[i] & (cnt_q == `PWMCT_CNT_RST);
      wire riseEdge = captureEnable[i] & sync2_q & ~pinPrev_q;
      wire fallEdge = captureEnable[i] & ~sync2_q & pinPrev_q;
      // a capture that raises its interrupt also restarts the period
      wire capIrq   = (riseEdge & riseLatchIrqEn[i]) |
                      (fallEdge & fallLatchIrqEn[i]);
      wire dzOn     = pairDeadzoneEnable[P];
      wire [DW-1:0] deadLim = dzOn ? deadCount[P*DW +: DW] : `PWMCT_DZ_RST;
      wire dzTick   = dzOn ? cntTick[M] : cntTick[i];
      reg  target;                        // undelayed output level

      assign cntTick[i] = preTick[P] & ((div_q & mask) == mask);
      assign rawHigh[i] = run_q & (cnt_q <= cmpA_q);
      assign runW[i]    = run_q;

      // free running divider stepped by the generator prescaler
      // never cleared on a start, so the first tick after a start may
      // come early by up to one divided period
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          div_q <= `PWMCT_DIVCNT_RST;
        else if (preTick[P])
          div_q <= div_q + 1'b1;
      end

      // period down counter with double-buffered period and compare
      // priority: stop, start, capture reload, zero event, plain tick
      // capture reload uses the active period, not the buffer
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cnt_q     <= `PWMCT_CNT_RST;
          perA_q    <= `PWMCT_CNT_RST;
          cmpA_q    <= `PWMCT_CNT_RST;
          run_q     <= 1'b0;
          runPrev_q <= 1'b0;
        end
        else
        begin
          runPrev_q <= timerRun[i];
          if (!timerRun[i])
            run_q <= 1'b0;
          else if (!runPrev_q)
          begin
            // start edge takes the buffers at once
            run_q  <= 1'b1;
            cnt_q  <= perBuf;
            perA_q <= perBuf;
            cmpA_q <= cmpBuf;
          end
          else if (run_q && capIrq)
            cnt_q <= perA_q;
          else if (zeroEvt)
          begin
            // buffers move only here and at the start edge, so no partial period escapes
            perA_q <= perBuf;
            cmpA_q <= cmpBuf;
            // auto-reload restarts from the newly taken period
            if (autoReload[i])
              cnt_q <= perBuf;
            else
              run_q <= 1'b0;
          end
          else if (run_q && cntTick[i])
            cnt_q <= cnt_q - 1'b1;
        end
      end

      // period flag, set wins over a same-cycle clear
      // a clear held longer than one cycle wipes a flag set during it on the next cycle
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          tFlag_q <= 1'b0;
        else
          tFlag_q <= (tFlag_q & ~timerFlagClr[i]) | zeroEvt;
      end

      // two-stage synchroniser, edges seen after the second stage only
      // the first stage may go metastable, so only the second feeds logic
      // pinPrev holds the level one clock older for edge detection
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sync1_q   <= 1'b0;
          sync2_q   <= 1'b0;
          pinPrev_q <= 1'b0;
        end
        else
        begin
          sync1_q   <= pinIn[i];
          sync2_q   <= sync1_q;
          pinPrev_q <= sync2_q;
        end
      end

      // capture latches and their flags
      // latches take the count before any same-edge reload or decrement
      // edges are flagged even with interrupts off, so software can poll
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          riseL_q <= `PWMCT_CNT_RST;
          fallL_q <= `PWMCT_CNT_RST;
          rFlag_q <= 1'b0;
          fFlag_q <= 1'b0;
        end
        else
        begin
          if (riseEdge)
            riseL_q <= cnt_q;
          if (fallEdge)
            fallL_q <= cnt_q;
          rFlag_q <= (rFlag_q & ~riseFlagClr[i]) | riseEdge;
          fFlag_q <= (fFlag_q & ~fallFlagClr[i]) | fallEdge;
        end
      end

      // pick the level before dead-zone delay
      // the odd side of a pair is the inverse of the even timer and
      // stays low whenever that timer is stopped
      always @*
      begin
        if (dzOn && (i % 2 == 0))
          target = rawHigh[M];
        else if (dzOn)
          target = runW[M] & ~rawHigh[M];
        else
          target = rawHigh[i];
      end

      // rising edges wait deadLim ticks, falling edges pass at once,
      // so the two sides of a pair are never high together
      // outside pair mode the limit is zero and a rise passes at once
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          dz_q  <= `PWMCT_DZ_RST;
          out_q <= 1'b0;
          oe_q  <= 1'b0;
        end
        else
        begin
          oe_q <= ~captureEnable[i];
          if (!target)
          begin
            dz_q  <= `PWMCT_DZ_RST;
            out_q <= 1'b0;
          end
          else if (dz_q >= deadLim)
            out_q <= 1'b1;
          else if (dzTick)
            dz_q <= dz_q + 1'b1;
        end
      end

      // sources pass only when their own enable is set
      // flags stay sticky; the enables gate the request line, and the capture ones also gate the period restart
      assign irqSrc[i] = (tFlag_q & timerIrqEn[i]) |
                         (rFlag_q & riseLatchIrqEn[i]) |
                         (fFlag_q & fallLatchIrqEn[i]);

      // every output below comes straight from a flip-flop
      assign pinOut[i]                    = out_q;
      assign pinOe[i]                     = oe_q;
      assign counterValue[i*CW +: CW]     = cnt_q;
      assign risingCaptureLatch[i*CW +: CW]  = riseL_q;
      assign fallingCaptureLatch[i*CW +: CW] = fallL_q;
      assign timerFlag[i]                 = tFlag_q;
      assign riseFlag[i]                  = rFlag_q;
      assign fallFlag[i]                  = fFlag_q;
      assign timerRunning[i]              = run_q;
    end
  endgenerate

  // single registered request line, one cycle behind the flags
  // registered so the line never glitches while flags settle
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_q <= 1'b0;
    else
      irq_q <= |irqSrc;
  end

  // level request, held while any enabled flag stays set
  assign pulseIrq = irq_q;

endmodule

// ---- rtl/pwmct_defs.vh ----
// Purpose: shared constants of the dual group pulse and capture timer
// Assumes: included by its bare name from the design files
// Notes:   definitions only, no logic
`ifndef PWMCT_DEFS_VH
`define PWMCT_DEFS_VH

// widths of the documented datapaths
`define PWMCT_CNT_W      16
`define PWMCT_PRE_W      8
`define PWMCT_DZ_W       8
`define PWMCT_DIVSEL_W   3
`define PWMCT_DIVCNT_W   4

// clock divider select codes
`define PWMCT_DIV_1      3'h0
`define PWMCT_DIV_2      3'h1
`define PWMCT_DIV_4      3'h2
`define PWMCT_DIV_8      3'h3
`define PWMCT_DIV_16     3'h4

// divider masks, tick when masked divider bits are all ones
`define PWMCT_MASK_1     4'h0
`define PWMCT_MASK_2     4'h1
`define PWMCT_MASK_4     4'h3
`define PWMCT_MASK_8     4'h7
`define PWMCT_MASK_16    4'hF

// reset values
`define PWMCT_CNT_RST    16'h0000
`define PWMCT_PRE_RST    8'h00
`define PWMCT_DZ_RST     8'h00
`define PWMCT_DIVCNT_RST 4'h0

`endif

// ---- verif/pwmct_top_props.sv ----
// Purpose: port checks on the dual group pulse and capture timer
// Assumes: one clock, async active low reset; timer 0, capture 1 watched
// Notes:   compare buffer of timer 0 held steady while it runs alone
`timescale 1ns/1ps
module pwmct_top_props
#(
  parameter CH  = 8,  // timers and pins
  parameter GEN = 4,  // generators
  parameter CW  = 16  // counter width
)
(
  input wire             clk,
  input wire             arst_n,
  input wire [CH*CW-1:0] periodBuf,
  input wire [CH*CW-1:0] compareBuf,
  input wire [CH-1:0]    autoReload,
  input wire [CH-1:0]    timerIrqEn,
  input wire [GEN-1:0]   pairDeadzoneEnable,
  input wire [CH-1:0]    captureEnable,
  input wire [CH-1:0]    riseLatchIrqEn,
  input wire [CH-1:0]    fallLatchIrqEn,
  input wire [CH-1:0]    timerFlagClr,
  input wire [CH-1:0]    pinOut,
  input wire [CH-1:0]    pinOe,
  input wire [CH*CW-1:0] counterValue,
  input wire [CH*CW-1:0] risingCaptureLatch,
  input wire [CH-1:0]    timerFlag,
  input wire [CH-1:0]    riseFlag,
  input wire [CH-1:0]    fallFlag,
  input wire             pulseIrq
);
  // all checks share the single clock and its reset
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_irq_gate: assert property (pulseIrq == $past(|(
    (timerFlag & timerIrqEn) | (riseFlag & riseLatchIrqEn) |
    (fallFlag & fallLatchIrqEn)))) else $error("irq not from enabled flags");
  chk_zero_flag: assert property ($rose(timerFlag[0]) |->
    $past(counterValue[CW-1:0]) == 0) else $error("flag set off zero");
  chk_clear_one: assert property ($fell(timerFlag[0]) |->
    $past(timerFlagClr[0])) else $error("flag dropped without clear");
  chk_pin_dir: assert property ($past(arst_n) |->
    pinOe == ~$past(captureEnable)) else $error("pin direction wrong");
  chk_auto_load: assert property ($rose(timerFlag[0]) &&
    $past(autoReload[0]) |-> counterValue[CW-1:0] == $past(periodBuf[CW-1:0]))
    else $error("reload not from period buffer");
  chk_high_match: assert property ($rose(pinOut[0]) &&
    $past(!pairDeadzoneEnable[0]) |->
    $past(counterValue[CW-1:0] <= compareBuf[CW-1:0]))
    else $error("output high before compare match");
  chk_rise_latch: assert property ($rose(riseFlag[1]) |->
    risingCaptureLatch[2*CW-1:CW] == $past(counterValue[2*CW-1:CW]))
    else $error("rising latch not the count");
  chk_cap_reload: assert property ($rose(riseFlag[1]) &&
    $past(riseLatchIrqEn[1]) |->
    counterValue[2*CW-1:CW] == $past(periodBuf[2*CW-1:CW]))
    else $error("capture did not reload counter");

  // main scenarios reached
  cover property ($rose(timerFlag[0]));
  cover property ($rose(riseFlag[1]));
  cover property ($rose(pulseIrq));
endmodule

bind pwmct_top pwmct_top_props #(.CH(CH), .GEN(GEN), .CW(CW)) props_u (
  .clk(clk), .arst_n(arst_n), .periodBuf(periodBuf),
  .compareBuf(compareBuf), .autoReload(autoReload), .timerIrqEn(timerIrqEn),
  .pairDeadzoneEnable(pairDeadzoneEnable), .captureEnable(captureEnable),
  .riseLatchIrqEn(riseLatchIrqEn), .fallLatchIrqEn(fallLatchIrqEn),
  .timerFlagClr(timerFlagClr), .pinOut(pinOut), .pinOe(pinOe),
  .counterValue(counterValue), .risingCaptureLatch(risingCaptureLatch),
  .timerFlag(timerFlag), .riseFlag(riseFlag), .fallFlag(fallFlag),
  .pulseIrq(pulseIrq));

// ---- verif/pwmct_pin_model.sv ----
// Purpose: far-side pins of the timer block, loads and capture sources
// Assumes: the bench sets each source level
// Notes:   a driven pin reads back the block's own level
`timescale 1ns/1ps
module pwmct_pin_model
(
  input  wire [7:0] pinOut,   // block output levels
  input  wire [7:0] pinOe,    // high while the block drives
  input  wire [7:0] srcLevel, // external signal on capture pins
  output wire [7:0] pinIn     // level seen on each pin
);
  // source only reaches a pin the block has let go
  assign pinIn = (pinOe & pinOut) | (~pinOe & srcLevel);
endmodule

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the pulse and capture timer block
// Assumes: inputs driven at rising edges, outputs read at falling edges
// Notes:   prescaler and divider at divide by one except the tick test
`timescale 1ns/1ps
`define CHK(nm, e, a) \
  begin totalChecks++; if ((a) !== (e)) begin errCount++; \
  $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module tb;
  reg          clk = 1'b0; // 10 MHz
  reg          arst_n;
  reg  [31:0]  prescale, deadCount;
  reg  [23:0]  divSel;
  reg  [127:0] periodBuf, compareBuf;
  reg  [7:0]   timerRun, autoReload, timerIrqEn, captureEnable, srcLevel;
  reg  [7:0]   riseLatchIrqEn, fallLatchIrqEn, timerFlagClr, riseFlagClr;
  reg  [7:0]   fallFlagClr, seen;
  reg  [3:0]   pairDeadzoneEnable;
  wire [7:0]   pinIn, pinOut, pinOe, timerFlag, riseFlag, fallFlag;
  wire [7:0]   timerRunning;
  wire [127:0] counterValue, risingCaptureLatch, fallingCaptureLatch;
  wire         pulseIrq;
  int          errCount = 0, totalChecks = 0, n, i;
  logic [15:0] cexp [5] = '{16'h1, 16'h0, 16'h4, 16'h3, 16'h2};

  always #50 clk = ~clk;

  pwmct_top dut_u (.clk(clk), .arst_n(arst_n), .prescale(prescale),
    .divSel(divSel), .periodBuf(periodBuf), .compareBuf(compareBuf),
    .timerRun(timerRun), .autoReload(autoReload), .timerIrqEn(timerIrqEn),
    .pairDeadzoneEnable(pairDeadzoneEnable), .deadCount(deadCount),
    .captureEnable(captureEnable), .riseLatchIrqEn(riseLatchIrqEn),
    .fallLatchIrqEn(fallLatchIrqEn), .timerFlagClr(timerFlagClr),
    .riseFlagClr(riseFlagClr), .fallFlagClr(fallFlagClr), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .counterValue(counterValue),
    .risingCaptureLatch(risingCaptureLatch),
    .fallingCaptureLatch(fallingCaptureLatch), .timerFlag(timerFlag),
    .riseFlag(riseFlag), .fallFlag(fallFlag), .timerRunning(timerRunning),
    .pulseIrq(pulseIrq));

  pwmct_pin_model pins_u (.pinOut(pinOut), .pinOe(pinOe),
    .srcLevel(srcLevel), .pinIn(pinIn));

  // verdict and end of run, also reached when a wait runs out
  task automatic printVerdict;
    if (errCount == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // bounded wait; k picks running, rising flag or falling flag
  task automatic waitFor(input int k, input int ch, input logic lvl,
                         output int cnt);
    logic [7:0] v;
    for (cnt = 1; cnt < 300; cnt++)
    begin
      @(negedge clk);
      v = (k == 0) ? timerRunning : (k == 1) ? riseFlag : fallFlag;
      if (v[ch] === lvl)
        return;
    end
    errCount++;
    $display("unexpected wait %0d exp %0h got %0h", k, lvl, v[ch]);
    printVerdict();
  endtask

  initial
  begin
    {prescale, divSel, periodBuf, compareBuf, deadCount} = '0;
    {timerRun, autoReload, timerIrqEn, captureEnable, srcLevel} = '0;
    {riseLatchIrqEn, fallLatchIrqEn, timerFlagClr, riseFlagClr} = '0;
    {fallFlagClr, pairDeadzoneEnable} = '0;
    arst_n = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // timer 0 auto reload; period buffer changed mid-count
    @(posedge clk);
    periodBuf[15:0] <= 16'h0002;
    compareBuf[15:0] <= 16'h0001;
    autoReload <= 8'h01;
    timerIrqEn <= 8'h01;
    @(posedge clk);
    timerRun[0] <= 1'b1;
    waitFor(0, 0, 1'b1, n);
    `CHK("count0", 16'h0002, counterValue[15:0])
    @(posedge clk);
    periodBuf[15:0] <= 16'h0004;
    for (i = 0; i < 5; i++)
    begin
      @(negedge clk);
      `CHK("count0", cexp[i], counterValue[15:0])
      `CHK("pin0", 1'(5'h06 >> i), pinOut[0])
    end
    `CHK("irq", 1'b1, pulseIrq)
    // mask and stop, then write-one clear
    @(posedge clk);
    timerIrqEn <= 8'h00;
    timerRun <= 8'h00;
    repeat (3) @(negedge clk);
    `CHK("masked irq", 1'b0, pulseIrq)
    @(posedge clk);
    timerFlagClr <= 8'h01;
    @(posedge clk);
    timerFlagClr <= 8'h00;
    @(negedge clk);
    `CHK("flag0", 1'b0, timerFlag[0])
    // timer 2 one-shot: period plus one counts, then halts
    @(posedge clk);
    periodBuf[47:32] <= 16'h0003;
    timerRun[2] <= 1'b1;
    waitFor(0, 2, 1'b1, n);
    waitFor(0, 2, 1'b0, n);
    `CHK("oneshot len", 4, n)
    @(posedge clk);
    timerFlagClr <= 8'h04;
    @(posedge clk);
    timerFlagClr <= 8'h00;
    repeat (12) @(negedge clk);
    `CHK("oneshot rerun", 2'h0, {timerFlag[2], timerRunning[2]})
    // channel 1 capture on a running timer
    @(posedge clk);
    periodBuf[31:16] <= 16'h0064;
    autoReload[1] <= 1'b1;
    timerRun <= 8'h02;
    @(posedge clk);
    captureEnable[1] <= 1'b1;
    riseLatchIrqEn[1] <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK("oe1", 1'b0, pinOe[1])
    @(posedge clk);
    srcLevel[1] <= 1'b1;
    waitFor(1, 1, 1'b1, n);
    `CHK("count1", 16'h0064, counterValue[31:16])
    `CHK("rise latch", 16'h0060, risingCaptureLatch[31:16])
    @(posedge clk);
    srcLevel[1] <= 1'b0;
    waitFor(2, 1, 1'b1, n);
    `CHK("fall latch", 16'(101 - n), fallingCaptureLatch[31:16])
    `CHK("count1", 16'(100 - n), counterValue[31:16])
    `CHK("irq", 1'b1, pulseIrq)
    // write-one clear of both capture flags drops the request
    @(posedge clk);
    riseFlagClr[1] <= 1'b1;
    fallFlagClr[1] <= 1'b1;
    @(posedge clk);
    {riseFlagClr, fallFlagClr} <= '0;
    repeat (2) @(negedge clk);
    `CHK("cap flags", 2'h0, {riseFlag[1], fallFlag[1]})
    `CHK("irq", 1'b0, pulseIrq)
    // all four pairs complementary with one dead tick
    @(posedge clk);
    captureEnable <= 8'h00;
    timerRun <= 8'h00;
    periodBuf <= {8{16'h0005}};
    compareBuf <= {8{16'h0002}};
    deadCount <= {4{8'h01}};
    autoReload <= 8'hFF;
    pairDeadzoneEnable <= 4'hF;
    @(posedge clk);
    timerRun <= 8'h55;
    seen = 8'h00;
    repeat (40)
    begin
      @(negedge clk);
      seen = seen | pinOut;
      `CHK("overlap", 7'h00, pinOut[6:0] & pinOut[7:1] & 7'h55)
    end
    `CHK("pair outs", 8'hFF, seen)
    // timer 3: prescale by two, divide by four, one tick per 8 clocks
    @(posedge clk);
    timerRun <= 8'h00;
    prescale[15:8] <= 8'h01;
    divSel[11:9] <= 3'h2;
    periodBuf[63:48] <= 16'h0010;
    @(posedge clk);
    timerRun[3] <= 1'b1;
    waitFor(0, 3, 1'b1, n);
    for (n = 0; n < 20 && counterValue[63:48] == 16'h0010; n++)
      @(negedge clk);
    `CHK("tick start", 16'h000F, counterValue[63:48])
    for (n = 0; n < 20 && counterValue[63:48] == 16'h000F; n++)
      @(negedge clk);
    `CHK("tick gap", 8, n)
    printVerdict();
  end
endmodule
